/* File: rtl/fbpwm_defs.svh */
`ifndef FBPWM_DEFS_SVH
`define FBPWM_DEFS_SVH

// clock and derived timing counts (least times round up)
`define FB_CLK_PERIOD_NS 20
`define FB_OSC_PERIOD_NS 1000
`define FB_OSC_CYC ((`FB_OSC_PERIOD_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)
`define FB_DEAD_NS 60
`define FB_DEAD_CYC ((`FB_DEAD_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)
`define FB_RESDLY_NS 100
`define FB_RESDLY_CYC ((`FB_RESDLY_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)
`define FB_BLANK_NS 100
`define FB_BLANK_CYC ((`FB_BLANK_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)
`define FB_SS_STEP_NS 1000
`define FB_SS_STEP_CYC ((`FB_SS_STEP_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)

// levels on the 8-bit converter scale
`define FB_SS_MAX 8'hFF
`define FB_LEB_EN_LEVEL 8'h22
`define FB_UV_ON_LEVEL 8'hB0
`define FB_UV_OFF_LEVEL 8'h98
`define FB_SUPPLY_LOSS_LEVEL 8'h20

// register port offsets
`define FB_REG_RESDLY 4'h0
`define FB_REG_BLANK 4'h4
`define FB_REG_DEAD 4'h8
`define FB_REG_STATUS 4'hC

// status field positions
`define FB_ST_SS_LSB 0
`define FB_ST_STATE_LSB 8
`define FB_ST_ENABLE 11
`define FB_ST_LOCKOUT 12
`define FB_ST_LATCHED 13

`endif

/* File: rtl/fbpwm_pkg.sv */
package fbpwm_pkg;
   typedef logic [7:0] fbpwm_cnt_t;
   typedef enum logic [2:0] {
      st_lockout = 3'h0,
      st_off = 3'h1,
      st_ramp = 3'h3,
      st_run = 3'h2,
      st_hiccup = 3'h6,
      st_latched = 3'h7
   } fbpwm_state_e;
endpackage

/* File: rtl/fbpwm_leg_if.sv */
`timescale 1ns/10ps
interface fbpwm_leg_if;
   import fbpwm_pkg::*;
   logic phase;
   fbpwm_cnt_t cnt;
   fbpwm_cnt_t osc_last;
   fbpwm_cnt_t dead;
   fbpwm_cnt_t resdly;
   fbpwm_cnt_t blank;
   logic blank_on;
   logic gate_en;
   logic trip;
   logic fault;
   logic high;
   logic low;
   logic rect;
   modport ctrl(output phase, cnt, osc_last, dead, resdly, blank, blank_on, gate_en, trip,
      fault, input high, low, rect);
   modport leg(input phase, cnt, osc_last, dead, resdly, blank, blank_on, gate_en, trip,
      fault, output high, low, rect);
endinterface

/* File: rtl/fbpwm_leg.sv */
`timescale 1ns/10ps
module fbpwm_leg #(
   parameter logic HIGH_PHASE = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // shared timing and gate outputs
   fbpwm_leg_if.leg lg
);
   import fbpwm_pkg::*;

   logic high_reg;
   logic low_reg;
   logic rect_reg;
   logic low_done_reg;
   fbpwm_cnt_t blank_cnt_reg;
   logic own_phase;
   logic period_end;
   logic blank_done;
   logic low_start;
   logic low_stop;
   logic [8:0] rect_sum;

   assign own_phase = (lg.phase == HIGH_PHASE);
   assign period_end = (lg.cnt == lg.osc_last);
   assign blank_done = !lg.blank_on || (blank_cnt_reg >= lg.blank);
   // low side only in the opposite phase, after the resonant delay, once per period
   assign low_start = !own_phase && lg.gate_en && (lg.cnt >= lg.resdly) && !low_done_reg
      && !high_reg;
   assign low_stop = lg.fault || !lg.gate_en || period_end || own_phase
      || (lg.trip && blank_done);
   assign rect_sum = {1'b0, lg.cnt} + {1'b0, lg.dead};

   // high side: whole own phase after the dead time, fixed duty
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         high_reg <= 1'b0;
      end else begin
         high_reg <= own_phase && lg.gate_en && (lg.cnt >= lg.dead) && !period_end
            && !low_reg;
      end
   end

   // rectifier ends one dead time before the high side of its leg
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rect_reg <= 1'b0;
      end else begin
         rect_reg <= own_phase && lg.gate_en && (lg.cnt >= lg.dead) && !period_end
            && !low_reg && (rect_sum < {1'b0, lg.osc_last});
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_reg <= 1'b0;
      end else if (low_stop) begin
         low_reg <= 1'b0;
      end else if (low_start) begin
         low_reg <= 1'b1;
      end
   end

   // a terminated pulse stays off until the next period
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_done_reg <= 1'b0;
      end else if (period_end) begin
         low_done_reg <= 1'b0;
      end else if (low_start) begin
         low_done_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         blank_cnt_reg <= '0;
      end else if (!low_reg) begin
         // held at zero between pulses, so a stale count cannot cut the next pulse at its start
         blank_cnt_reg <= '0;
      end else if (!blank_done) begin
         blank_cnt_reg <= blank_cnt_reg + 8'h01;
      end
   end

   assign lg.high = high_reg;
   assign lg.low = low_reg;
   assign lg.rect = rect_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_leg_no_overlap: assert property (!(lg.high && lg.low))
      else $error("high and low side of one leg both on");
   a_high_dead_time: assert property ($rose(lg.high) |-> (lg.cnt > lg.dead))
      else $error("high side rose inside the dead time");
   a_low_resonant_delay: assert property ($rose(lg.low) |-> (lg.cnt > lg.resdly))
      else $error("low side rose before the resonant delay");
   a_blank_holds_pulse: assert property (lg.low && !blank_done && lg.trip && lg.gate_en
      && !lg.fault && !period_end && !own_phase |=> lg.low)
      else $error("pulse ended by a trip inside the blanking time");
   a_rect_before_high: assert property (lg.rect |-> lg.high
      && ({1'b0, lg.cnt} <= {1'b0, lg.osc_last} - {1'b0, lg.dead} + 9'h001))
      else $error("rectifier on without high side or past its early end");
endmodule

/* File: rtl/fbpwm_top.sv */
`timescale 1ns/10ps
`include "fbpwm_defs.svh"
module fbpwm_top #(
   parameter fbpwm_pkg::fbpwm_cnt_t OSC_CYC = 8'(`FB_OSC_CYC),
   parameter logic [15:0] SS_STEP_CYC = 16'(`FB_SS_STEP_CYC)
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // asynchronous pins
   input wire logic enable_in,
   input wire logic peak_current_fault,
   input wire logic latching_shutdown_in,
   // converter samples on core_clk
   input wire fbpwm_pkg::fbpwm_cnt_t supply_level,
   input wire fbpwm_pkg::fbpwm_cnt_t modulation_demand,
   input wire fbpwm_pkg::fbpwm_cnt_t regulation_reference_in,
   input wire fbpwm_pkg::fbpwm_cnt_t current_sense,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // bridge and rectifier gates
   output logic high_side_gate_a,
   output logic high_side_gate_b,
   output logic low_side_gate_a,
   output logic low_side_gate_b,
   output logic rectifier_gate_a,
   output logic rectifier_gate_b,
   // status
   output fbpwm_pkg::fbpwm_cnt_t soft_start_level,
   output fbpwm_pkg::fbpwm_cnt_t limited_reference,
   output logic supply_lockout
);
   import fbpwm_pkg::*;

   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic en_s;
   logic fault_s;
   logic lat_s;
   fbpwm_state_e state_reg;
   fbpwm_state_e state_next;
   logic latch_reg;
   logic lockout_reg;
   fbpwm_cnt_t cnt_reg;
   logic phase_reg;
   logic period_end;
   fbpwm_cnt_t ss_reg;
   logic [15:0] ss_step_reg;
   fbpwm_cnt_t resdly_reg;
   fbpwm_cnt_t blank_reg;
   fbpwm_cnt_t dead_reg;
   fbpwm_cnt_t demand_lim_reg;
   fbpwm_cnt_t ref_lim_reg;
   logic trip_reg;
   logic gate_en;
   logic [15:0] rdata_reg;
   logic [15:0] status_word;

   fbpwm_leg_if leg_a_if();
   fbpwm_leg_if leg_b_if();

   // two-stage synchronisers for the pins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
      end else begin
         pin_meta_reg <= {latching_shutdown_in, peak_current_fault, enable_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign en_s = pin_sync_reg[0];
   assign fault_s = pin_sync_reg[1];
   assign lat_s = pin_sync_reg[2];

   // supply lockout with hysteresis, starts locked
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lockout_reg <= 1'b1;
      end else if (supply_level < `FB_UV_OFF_LEVEL) begin
         lockout_reg <= 1'b1;
      end else if (supply_level >= `FB_UV_ON_LEVEL) begin
         lockout_reg <= 1'b0;
      end
   end

   // shutdown latch: set wins, enable has no say, only supply loss clears it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_reg <= 1'b0;
      end else if (lat_s) begin
         latch_reg <= 1'b1;
      end else if (supply_level < `FB_SUPPLY_LOSS_LEVEL) begin
         latch_reg <= 1'b0;
      end
   end

   // oscillator period counter; phase toggles each period, so legs alternate
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         phase_reg <= 1'b0;
      end else if (period_end) begin
         cnt_reg <= '0;
         phase_reg <= !phase_reg;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
   assign period_end = (cnt_reg == OSC_CYC - 8'h01);

   always_comb begin
      state_next = state_reg;
      if (latch_reg || lat_s) begin
         state_next = st_latched;
      end else if (lockout_reg) begin
         state_next = st_lockout;
      end else if (!en_s) begin
         state_next = st_off;
      end else begin
         case (state_reg)
            st_lockout,
            st_off,
            st_latched: begin
               state_next = fault_s ? st_hiccup : st_ramp;
            end
            st_ramp: begin
               if (fault_s) begin
                  state_next = st_hiccup;
               end else if (ss_reg == `FB_SS_MAX) begin
                  state_next = st_run;
               end
            end
            st_run: begin
               if (fault_s) begin
                  state_next = st_hiccup;
               end
            end
            st_hiccup: begin
               // held off to the period edge, then a slow ramp again
               if (period_end && !fault_s) begin
                  state_next = st_ramp;
               end
            end
            default: begin
               state_next = st_lockout;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= st_lockout;
      end else begin
         state_reg <= state_next;
      end
   end

   // gates only in ramp or run; the synced pins cut them without waiting for the state
   assign gate_en = ((state_reg == st_ramp) || (state_reg == st_run)) && en_s && !fault_s
      && !lat_s && !latch_reg && !lockout_reg;

   // soft-start: slow climb, cleared in one cycle whenever gates are disabled
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ss_reg <= '0;
         ss_step_reg <= '0;
      end else if (!gate_en) begin
         ss_reg <= '0;
         ss_step_reg <= '0;
      end else if (ss_step_reg == SS_STEP_CYC - 16'h0001) begin
         ss_step_reg <= '0;
         if (ss_reg != `FB_SS_MAX) begin
            ss_reg <= ss_reg + 8'h01;
         end
      end else begin
         ss_step_reg <= ss_step_reg + 16'h0001;
      end
   end

   // demand and reference clamped to the soft-start level; trip is the current compare
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         demand_lim_reg <= '0;
         ref_lim_reg <= '0;
         trip_reg <= 1'b0;
      end else begin
         demand_lim_reg <= (modulation_demand > ss_reg) ? ss_reg : modulation_demand;
         ref_lim_reg <= (regulation_reference_in > ss_reg) ? ss_reg
            : regulation_reference_in;
         trip_reg <= (current_sense >= demand_lim_reg);
      end
   end

   // timing counts come up at their defaults; software may retune them
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         resdly_reg <= 8'(`FB_RESDLY_CYC);
         blank_reg <= 8'(`FB_BLANK_CYC);
         dead_reg <= 8'(`FB_DEAD_CYC);
      end else if (reg_wr) begin
         case (reg_addr)
            `FB_REG_RESDLY: resdly_reg <= reg_wdata[7:0];
            `FB_REG_BLANK: blank_reg <= reg_wdata[7:0];
            `FB_REG_DEAD: dead_reg <= reg_wdata[7:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      status_word = 16'h0000;
      status_word[`FB_ST_SS_LSB +: 8] = ss_reg;
      status_word[`FB_ST_STATE_LSB +: 3] = state_reg;
      status_word[`FB_ST_ENABLE] = en_s;
      status_word[`FB_ST_LOCKOUT] = lockout_reg;
      status_word[`FB_ST_LATCHED] = latch_reg;
   end

   // read data stand only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `FB_REG_RESDLY: rdata_reg <= {8'h00, resdly_reg};
            `FB_REG_BLANK: rdata_reg <= {8'h00, blank_reg};
            `FB_REG_DEAD: rdata_reg <= {8'h00, dead_reg};
            `FB_REG_STATUS: rdata_reg <= status_word;
            default: rdata_reg <= 16'h0000;
         endcase
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   // both legs see the same timing; a blanking count of zero turns blanking off
   assign leg_a_if.phase = phase_reg;
   assign leg_a_if.cnt = cnt_reg;
   assign leg_a_if.osc_last = OSC_CYC - 8'h01;
   assign leg_a_if.dead = dead_reg;
   assign leg_a_if.resdly = resdly_reg;
   assign leg_a_if.blank = blank_reg;
   assign leg_a_if.blank_on = (ss_reg > `FB_LEB_EN_LEVEL) && (blank_reg != 8'h00);
   assign leg_a_if.gate_en = gate_en;
   assign leg_a_if.trip = trip_reg;
   assign leg_a_if.fault = fault_s;
   assign leg_b_if.phase = phase_reg;
   assign leg_b_if.cnt = cnt_reg;
   assign leg_b_if.osc_last = OSC_CYC - 8'h01;
   assign leg_b_if.dead = dead_reg;
   assign leg_b_if.resdly = resdly_reg;
   assign leg_b_if.blank = blank_reg;
   assign leg_b_if.blank_on = (ss_reg > `FB_LEB_EN_LEVEL) && (blank_reg != 8'h00);
   assign leg_b_if.gate_en = gate_en;
   assign leg_b_if.trip = trip_reg;
   assign leg_b_if.fault = fault_s;

   fbpwm_leg #(
      .HIGH_PHASE(1'b0)
   ) u_leg_a (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .lg(leg_a_if.leg)
   );

   fbpwm_leg #(
      .HIGH_PHASE(1'b1)
   ) u_leg_b (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .lg(leg_b_if.leg)
   );

   assign high_side_gate_a = leg_a_if.high;
   assign low_side_gate_a = leg_a_if.low;
   assign rectifier_gate_a = leg_a_if.rect;
   assign high_side_gate_b = leg_b_if.high;
   assign low_side_gate_b = leg_b_if.low;
   assign rectifier_gate_b = leg_b_if.rect;
   assign reg_rdata = rdata_reg;
   assign soft_start_level = ss_reg;
   assign limited_reference = ref_lim_reg;
   assign supply_lockout = lockout_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_trip_in_run;
      (state_reg == st_run) && fault_s && en_s && !lat_s && !latch_reg && !lockout_reg;
   endsequence
   sequence s_hiccup_release;
      (state_reg == st_hiccup) && period_end && !fault_s && en_s && !lat_s && !latch_reg
         && !lockout_reg;
   endsequence

   a_enable_clears_ss: assert property (!en_s |=> (ss_reg == 8'h00) && !rectifier_gate_a
      && !rectifier_gate_b)
      else $error("soft-start or rectifier not cleared with enable low");
   a_enable_ramp_start: assert property ((state_reg == st_off) && en_s && !fault_s && !lat_s
      && !latch_reg && !lockout_reg |=> (state_reg == st_ramp))
      else $error("no ramp after enable returned");
   a_fault_gates_off: assert property (fault_s |=> !low_side_gate_a && !low_side_gate_b
      && !high_side_gate_a && !high_side_gate_b && (ss_reg == 8'h00))
      else $error("gates or soft-start not cleared on peak fault");
   a_hiccup_entry: assert property (s_trip_in_run |=> (state_reg == st_hiccup))
      else $error("trip in run did not enter hiccup");
   a_hiccup_restart: assert property (s_hiccup_release |=> (state_reg == st_ramp))
      else $error("hiccup did not ramp again at the period edge");
   a_latch_priority: assert property (latch_reg |=> (state_reg == st_latched))
      else $error("latched device left the latched state");
   a_latch_holds: assert property (latch_reg && (supply_level >= `FB_SUPPLY_LOSS_LEVEL)
      |=> latch_reg)
      else $error("shutdown latch cleared without supply loss");
   a_lockout_gates: assert property (lockout_reg |=> !high_side_gate_a && !high_side_gate_b
      && !low_side_gate_a && !low_side_gate_b)
      else $error("gate on during supply lockout");
   a_lockout_entry: assert property (supply_level < `FB_UV_OFF_LEVEL |=> lockout_reg)
      else $error("lockout not entered below turn-off level");
   a_phase_alternate: assert property (period_end |=> (phase_reg != $past(phase_reg))
      && (cnt_reg == 8'h00))
      else $error("phase did not alternate at period end");
   a_reference_clamp: assert property (limited_reference <= $past(ss_reg))
      else $error("limited reference above soft-start level");
endmodule

/* File: dv/fbpwm_gate_drv.sv */
`timescale 1ns/10ps
module fbpwm_gate_drv (
   // clock
   input wire logic core_clk,
   // gate commands: hi a, hi b, lo a, lo b, rect a, rect b from bit 0 up
   input wire logic [5:0] gate_cmd,
   // switch states and leg overlap flag
   output logic [5:0] sw_on,
   output logic shoot_thru
);
   initial sw_on = 6'h00;
   // one clock of driver delay; a real driver skews more, so overlap here is a floor
   always @(posedge core_clk) begin
      sw_on <= gate_cmd;
   end
   assign shoot_thru = (sw_on[0] & sw_on[2]) | (sw_on[1] & sw_on[3]);
endmodule

/* File: dv/fbpwm_tb.sv */
`timescale 1ns/10ps
module full_bridge_pwm_fault_sequencer_test;
   import fbpwm_pkg::*;
   localparam int OSC = 20;
   localparam int DEAD = 3;
   localparam int BLANK = 5;
   logic core_clk = 1'b0, sys_rst = 1'b1, enable_in = 1'b0, rnd_on = 1'b0, mon_on = 1'b0;
   logic peak_current_fault = 1'b0, latching_shutdown_in = 1'b0;
   fbpwm_cnt_t supply_level = 8'h00, modulation_demand = 8'h80;
   fbpwm_cnt_t regulation_reference_in = 8'h80, current_sense = 8'h00;
   fbpwm_cnt_t ss, lim, p_ref, p_ss;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, lock, shoot;
   logic [5:0] g, sw_on;
   int n_fail = 0, n_checks = 0, seed = 39465, w, gap;
   realtime t1, t2;
   fbpwm_top #(.OSC_CYC(8'(OSC)), .SS_STEP_CYC(16'h0002)) dut (.core_clk(core_clk),
      .sys_rst(sys_rst), .enable_in(enable_in), .peak_current_fault(peak_current_fault),
      .latching_shutdown_in(latching_shutdown_in), .supply_level(supply_level),
      .modulation_demand(modulation_demand), .regulation_reference_in(regulation_reference_in),
      .current_sense(current_sense), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_gate_a(g[0]),
      .high_side_gate_b(g[1]), .low_side_gate_a(g[2]), .low_side_gate_b(g[3]),
      .rectifier_gate_a(g[4]), .rectifier_gate_b(g[5]), .soft_start_level(ss),
      .limited_reference(lim), .supply_lockout(lock));
   fbpwm_gate_drv drv (.core_clk(core_clk), .gate_cmd(g), .sw_on(sw_on), .shoot_thru(shoot));
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (rnd_on) begin
         regulation_reference_in <= 8'($random(seed));
         modulation_demand <= 8'($random(seed));
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk(reg_rdata, e);
      @(posedge core_clk);
   endtask
   // bounded wait for the ramp; the bound covers a full climb at the short step
   task automatic wait_ss(input int v);
      int i;
      for (i = 0; i < 2000 && ss <= v; i++) @(negedge core_clk);
      chk(16'(i < 2000), 16'h0001);
      @(posedge core_clk);
   endtask
   task automatic pw(input int s);
      int i;
      w = 0;
      gap = 0;
      for (i = 0; i < 4 * OSC && g[s] !== 1'b0; i++) @(negedge core_clk);
      for (i = 0; i < 4 * OSC && g[s] !== 1'b1; i++) @(negedge core_clk);
      if (i >= 4 * OSC) begin
         n_fail++;
         $display("[FAIL] t=%0t no pulse on gate %h", $time, s);
      end
      t1 = t2;
      t2 = $realtime;
      while (g[s] === 1'b1 && w < 4 * OSC) begin
         w++;
         if (s < 2 && g[s + 4] !== 1'b1) gap++;
         @(negedge core_clk);
      end
      @(posedge core_clk);
   endtask
   task automatic close_out;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(negedge core_clk) begin
      if (!sys_rst && mon_on) begin
         chk({15'h0000, (g[0] & g[2]) | (g[1] & g[3]) | shoot}, 16'h0000);
         chk({8'h00, lim}, {8'h00, (p_ref < p_ss) ? p_ref : p_ss});
      end
      p_ref = regulation_reference_in;
      p_ss = ss;
   end
   initial begin
      cyc(6);
      sys_rst <= 1'b0;
      cyc(1);
      chk({15'h0000, lock}, 16'h0001);
      rd(4'h0, 16'h0005);
      rd(4'h4, 16'h0005);
      rd(4'h8, 16'h0003);
      rd(4'h2, 16'h0000);
      wr(4'hC, 16'hFFFF);
      rd(4'hC, 16'h1000);
      wr(4'h0, 16'h1206);
      rd(4'h0, 16'h0006);
      wr(4'h0, 16'h0005);
      supply_level <= 8'hB0;
      enable_in <= 1'b1;
      rnd_on <= 1'b1;
      mon_on <= 1'b1;
      wait_ss(8'h30);
      chk({15'h0000, lock}, 16'h0000);
      pw(0);
      chk(16'(w), 16'(OSC - DEAD - 1));
      chk(16'(gap == DEAD || gap == DEAD + 1), 16'h0001);
      pw(0);
      chk(16'(int'((t2 - t1) / 20.0)), 16'(2 * OSC));
      pw(1);
      chk(16'(w), 16'(OSC - DEAD - 1));
      // every comparison trips once blanking ends, so the pulse is as long as the blank
      current_sense <= 8'hFF;
      pw(2);
      chk(16'(w >= BLANK && w <= BLANK + 2), 16'h0001);
      wr(4'h4, 16'h0000);
      // with blanking off a standing trip cuts the pulse at once, over two periods
      w = 0;
      repeat (2 * OSC) begin
         @(negedge core_clk);
         if (g[3] === 1'b1) w++;
      end
      @(posedge core_clk);
      chk(16'(w <= 2), 16'h0001);
      wr(4'h4, 16'h0005);
      current_sense <= 8'h00;
      enable_in <= 1'b0;
      cyc(5);
      chk({10'h000, g}, 16'h0000);
      chk({8'h00, ss}, 16'h0000);
      enable_in <= 1'b1;
      // climb to full scale so the fault below strikes in normal running
      wait_ss(8'hFE);
      peak_current_fault <= 1'b1;
      cyc(5);
      chk({10'h000, g}, 16'h0000);
      chk({8'h00, ss}, 16'h0000);
      cyc(3 * OSC);
      chk({8'h00, ss}, 16'h0000);
      peak_current_fault <= 1'b0;
      wait_ss(8'h10);
      latching_shutdown_in <= 1'b1;
      cyc(5);
      chk({10'h000, g}, 16'h0000);
      chk({8'h00, ss}, 16'h0000);
      latching_shutdown_in <= 1'b0;
      enable_in <= 1'b0;
      cyc(5);
      enable_in <= 1'b1;
      cyc(4 * OSC);
      chk({8'h00, ss}, 16'h0000);
      rd(4'hC, 16'h2F00);
      supply_level <= 8'h90;
      cyc(5);
      supply_level <= 8'hB0;
      cyc(4 * OSC);
      chk({8'h00, ss}, 16'h0000);
      supply_level <= 8'h10;
      cyc(5);
      supply_level <= 8'hB0;
      wait_ss(8'h10);
      supply_level <= 8'hA0;
      cyc(5);
      chk({15'h0000, lock}, 16'h0000);
      supply_level <= 8'h97;
      cyc(3);
      chk({9'h000, lock, g}, 16'h0040);
      supply_level <= 8'hA0;
      cyc(3);
      chk({15'h0000, lock}, 16'h0001);
      supply_level <= 8'hB0;
      cyc(3);
      chk({15'h0000, lock}, 16'h0000);
      close_out();
   end
endmodule
